// [bench/nvm_model.sv]
// Behavioural serial configuration memory of 64 words of 16 bits
`timescale 1ns/100ps
`include "eeprom_config_loader_cfg.svh"
module nvm_model (
    input wire logic cs,
    input wire logic sk,
    input wire logic mosi,
    output logic miso,
    output logic [7:0] words_read,
    output logic bad_cmd
);
    logic [15:0] mem [0:63];
    logic [15:0] word;
    logic [8:0] cmd;
    logic [5:0] exp_addr;
    int bit_n;
    initial begin
        miso = 1'b0;
        words_read = 8'h00;
        bad_cmd = 1'b0;
        exp_addr = 6'h00;
        bit_n = 0;
        cmd = 9'h000;
        word = 16'h0000;
    end
    always @(posedge cs) bit_n = 0;
    // Released line shows no stale level
    always @(negedge cs) miso = ~miso;
    always @(posedge sk) begin
        if (cs) begin
            if (bit_n < 9) cmd = {cmd[7:0], mosi};
            if (bit_n < 8) miso = ~miso;
            else if (bit_n == 8) begin
                if (cmd[8:6] !== `NVM_CMD_READ || cmd[5:0] !== exp_addr) bad_cmd = 1'b1;
                word = mem[cmd[5:0]];
                exp_addr = exp_addr + 6'h01;
                words_read = words_read + 8'h01;
                miso = 1'b0;
            end else if (bit_n < 25) miso = word[24 - bit_n];
            bit_n++;
        end
    end
endmodule : nvm_model

// [bench/tb_eeprom_config_loader.sv]
// Testbench of the configuration loader with APB master and memory model
`timescale 1ns/100ps
`include "eeprom_config_loader_cfg.svh"
module tb_eeprom_config_loader import eeprom_config_loader_pkg::*;;
    localparam logic [15:0] VEN_DEF = 16'h1F2E; // Arbitrary value
    localparam logic [15:0] DEV_DEF = 16'h6B4D; // Arbitrary value
    localparam logic [11:0] ST = `OFS_LOADER_STATUS_REG;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [`APB_AW-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, nvm_cs, nvm_sk, nvm_mosi, nvm_miso, bad_cmd;
    logic [7:0] words_read, n0;
    logic [15:0] seed = 16'h001D;
    logic [15:0] exp_f [0:5];
    logic [5:0] mask;
    logic [31:0] rd;
    logic err;
    int mismatches = 0;
    int total_checks = 0;

    always #4 clk_sys = ~clk_sys;

    eeprom_config_loader #(.VENDOR_ID_DEFAULT(VEN_DEF), .DEVICE_ID_DEFAULT(DEV_DEF)) DUT (
        .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .nvm_cs(nvm_cs), .nvm_sk(nvm_sk), .nvm_mosi(nvm_mosi), .nvm_miso(nvm_miso));

    nvm_model u_nvm (.cs(nvm_cs), .sk(nvm_sk), .mosi(nvm_mosi), .miso(nvm_miso),
        .words_read(words_read), .bad_cmd(bad_cmd));

    function automatic logic [15:0] next_rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction : next_rnd

    function automatic logic [31:0] exp_reg(input logic [11:0] a);
        case (a)
            `OFS_IDS: return {exp_f[1], exp_f[0]};
            `OFS_CLASS: return {8'h00, exp_f[3], exp_f[2][15:8]};
            `OFS_SUBSYS: return {exp_f[5], exp_f[4]};
            default: return 32'h0;
        endcase
    endfunction : exp_reg

    function automatic logic [31:0] exp_st(input logic par);
        return {18'h0, mask, 4'h0, par, 3'b001};
    endfunction : exp_st

    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] d, output logic e);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) mismatches++;
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rd, err);
        check(rd, exp);
        check({31'h0, err}, 32'h0);
    endtask : rd_chk

    task defaults();
        exp_f[0] = VEN_DEF;
        exp_f[1] = DEV_DEF;
        exp_f[2] = `DEF_CLASS_LO;
        exp_f[3] = `DEF_CLASS_HI;
        exp_f[4] = `DEF_SUBSYS;
        exp_f[5] = `DEF_SUBSYS;
        mask = 6'h00;
    endtask : defaults

    task chk_defaults();
        rd_chk(`OFS_IDS, {DEV_DEF, VEN_DEF});
        rd_chk(`OFS_CLASS, 32'h00070002);
        rd_chk(`OFS_SUBSYS, 32'h0);
        rd_chk(ST, 32'h2);
    endtask : chk_defaults

    task chk_all();
        rd_chk(`OFS_IDS, exp_reg(`OFS_IDS));
        rd_chk(`OFS_CLASS, exp_reg(`OFS_CLASS));
        rd_chk(`OFS_SUBSYS, exp_reg(`OFS_SUBSYS));
    endtask : chk_all

    task put_pair(input int idx, input logic [7:0] tgt, input logic fin, input logic good, input logic [15:0] d);
        logic [15:0] a;
        a = {1'b0, fin, 6'h00, tgt};
        a[15] = ~(^{a[14:0], d}) ^ ~good;
        u_nvm.mem[2 * idx] = a;
        u_nvm.mem[2 * idx + 1] = d;
        if (good) begin
            exp_f[tgt] = d;
            mask[tgt] = 1'b1;
        end
    endtask : put_pair

    task wait_done();
        int i;
        i = 0;
        rd = 32'h0;
        while (i < 15000 && rd[0] !== 1'b1) begin
            apb(1'b0, ST, 32'h0, rd, err);
            i++;
        end
        if (i >= 15000) mismatches++;
    endtask : wait_done

    task stop_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : stop_test

    initial begin
        repeat (75000) @(posedge clk_sys);
        mismatches++;
        $display("test watchdog expired");
        stop_test();
    end

    initial begin
        put_pair(5, `TGT_SS_VENDOR, 1'b0, 1'b1, next_rnd());
        defaults();
        put_pair(0, `TGT_SS_ID, 1'b0, 1'b1, next_rnd());
        put_pair(1, `TGT_CLASS_LO, 1'b0, 1'b1, next_rnd());
        put_pair(2, `TGT_VENDOR, 1'b0, 1'b0, next_rnd());
        put_pair(3, `TGT_CLASS_HI, 1'b0, 1'b1, next_rnd());
        put_pair(4, `TGT_DEVICE, 1'b1, 1'b1, next_rnd());
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (10) @(posedge clk_sys);
        chk_defaults();
        wait_done();
        check({24'h0, words_read}, 32'hA);
        check({31'h0, bad_cmd}, 32'h0);
        chk_all();
        rd_chk(ST, exp_st(1'b1));
        $display("test load_mixed done");
        apb(1'b1, `OFS_IDS, {next_rnd(), next_rnd()}, rd, err);
        check({31'h0, err}, 32'h0);
        chk_all();
        apb(1'b0, 12'h00C, 32'h0, rd, err);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        apb(1'b1, 12'h0FC, 32'hFFFFFFFF, rd, err);
        check({31'h0, err}, 32'h1);
        apb(1'b1, ST, 32'h8, rd, err);
        rd_chk(ST, exp_st(1'b0));
        rd_chk(`OFS_CTRL, 32'h0);
        $display("test registers done");
        n0 = words_read;
        u_nvm.exp_addr = 6'h00;
        defaults();
        put_pair(0, `TGT_SS_VENDOR, 1'b0, 1'b0, next_rnd());
        put_pair(1, `TGT_VENDOR, 1'b0, 1'b1, next_rnd());
        put_pair(2, `TGT_SS_VENDOR, 1'b1, 1'b1, next_rnd());
        apb(1'b1, `OFS_CTRL, 32'h1, rd, err);
        repeat (10) @(posedge clk_sys);
        chk_defaults();
        apb(1'b1, `OFS_CTRL, 32'h1, rd, err);
        wait_done();
        check({24'h0, words_read - n0}, 32'h6);
        check({31'h0, bad_cmd}, 32'h0);
        chk_all();
        rd_chk(ST, exp_st(1'b1));
        $display("test reload done");
        stop_test();
    end
endmodule : tb_eeprom_config_loader

// [pkg/eeprom_config_loader_cfg.svh]
// Offsets, field positions, defaults and timing of the configuration loader
// How it works
// - Serial memory holds 16-bit words, read at power-up to program config fields.
// - Words come in pairs: address descriptor first, then the data word.
// - Descriptor bit 15 gives odd parity over all 32 bits of the pair.
// - A pair with bad parity sets bit 3 of the loader status register.
// - Descriptor bit 14 set ends loading after this pair; clear means continue, except after the pair ending at memory word 63.
// - Codes 0, 1, 4, 5 load vendor, device, subsystem vendor, subsystem id.
// - Code 2 loads class bits 7:0 from data high byte; code 3 bits 23:8.
// - Pairs are accepted in any order and each goes to its own target.
// - Fields not named by any pair keep their defaults.
`ifndef EEPROM_CONFIG_LOADER_CFG_SVH
`define EEPROM_CONFIG_LOADER_CFG_SVH
`define CLK_PERIOD_NS 8
`define NVM_SK_HALF_NS 500
`define NVM_SK_HALF_CYC ((`NVM_SK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define APB_AW 12
`define OFS_IDS 12'h000
`define OFS_CLASS 12'h004
`define OFS_SUBSYS 12'h008
`define OFS_CTRL 12'h010
`define IDX_LOADER_STATUS_REG 10'h08E
`define OFS_LOADER_STATUS_REG ({`IDX_LOADER_STATUS_REG, 2'b00})
`define ST_DONE_BIT 0
`define ST_BUSY_BIT 1
`define ST_PARITY_BIT 3
`define ST_LOADED_LSB 8
`define CTRL_RELOAD_BIT 0
`define DESC_PARITY_BIT 15
`define DESC_FINAL_BIT 14
`define TGT_VENDOR 8'h00
`define TGT_DEVICE 8'h01
`define TGT_CLASS_LO 8'h02
`define TGT_CLASS_HI 8'h03
`define TGT_SS_VENDOR 8'h04
`define TGT_SS_ID 8'h05
`define NUM_TARGETS 8'h06
`define DEF_CLASS_LO 16'h0200
`define DEF_CLASS_HI 16'h0700
`define DEF_SUBSYS 16'h0000
`define NVM_CMD_READ 3'b110
`define NVM_LAST_ADDR 6'h3F
`define NVM_SHIFT_BITS 5'h19
`define NVM_DATA_FIRST 5'h09
`endif

// [pkg/eeprom_config_loader_pkg.sv]
// Types shared by the configuration loader files
package eeprom_config_loader_pkg;
    typedef enum logic [2:0] {LD_IDLE, LD_ADDR, LD_DATA, LD_APPLY, LD_DONE} load_state_t;
    typedef enum logic [1:0] {RD_IDLE, RD_SHIFT, RD_END} read_state_t;
    typedef struct packed {
        logic parity_ok;
        logic last;
        logic [7:0] target;
    } pair_info_t;
    typedef struct packed {
        logic [15:0] vendor;
        logic [15:0] device;
        logic [23:0] class_code;
        logic [15:0] ss_vendor;
        logic [15:0] ss_id;
    } cfg_fields_t;
endpackage : eeprom_config_loader_pkg

// [verilog/eeprom_config_loader.sv]
// Power-up loader of configuration fields from serial memory, with APB registers
`timescale 1ns/100ps
`include "eeprom_config_loader_cfg.svh"
module eeprom_config_loader import eeprom_config_loader_pkg::*; #(
    parameter logic [15:0] VENDOR_ID_DEFAULT = 16'h5A5A,
    parameter logic [15:0] DEVICE_ID_DEFAULT = 16'hC3C3
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic nvm_cs,
    output logic nvm_sk,
    output logic nvm_mosi,
    input wire logic nvm_miso
);
    // ID defaults above are arbitrary values
    localparam logic [15:0] CLASS_LO_DEF = `DEF_CLASS_LO;
    localparam logic [15:0] HALF_CYC = 16'(`NVM_SK_HALF_CYC);

    logic rst_s1_q, rst_n_q;
    logic miso_s1_q, miso_s2_q;
    logic [15:0] div_q, div_d;
    logic tick_q, tick_d;

    load_state_t st_q, st_d;
    logic [5:0] waddr_q, waddr_d;
    logic [15:0] aword_q, aword_d, dword_q, dword_d;
    cfg_fields_t fields_q, fields_d, dflt, visible;
    logic [5:0] field_loaded_from_nvm_q, field_loaded_from_nvm_d;
    logic perr_q, perr_d, done_q, done_d, rd_start_q, rd_start_d, kick_q;
    logic rd_valid;
    logic [15:0] rd_word;
    pair_info_t info;

    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d, rd_mux;
    logic setup, access, mapped, reload, perr_clr, busy;

    // Reset release and input synchroniser
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            miso_s1_q <= 1'b0;
            miso_s2_q <= 1'b0;
        end else begin
            miso_s1_q <= nvm_miso;
            miso_s2_q <= miso_s1_q;
        end
    end

    // Serial clock half-period divider
    always_comb begin
        tick_d = 1'b0;
        div_d = div_q + 16'h0001;
        if (div_q == HALF_CYC - 16'h0001) begin
            div_d = 16'h0000;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            div_q <= 16'h0000;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_d;
            tick_q <= tick_d;
        end
    end

    nvm_word_reader u_reader (
        .clk_sys(clk_sys),
        .rst_n(rst_n_q),
        .tick(tick_q),
        .start(rd_start_q),
        .word_addr(waddr_q),
        .miso_s(miso_s2_q),
        .word_valid(rd_valid),
        .word(rd_word),
        .cs(nvm_cs),
        .sk(nvm_sk),
        .mosi(nvm_mosi)
    );

    pair_decoder u_decoder (
        .addr_word(aword_q),
        .data_word(dword_q),
        .info(info)
    );

    assign dflt = {VENDOR_ID_DEFAULT, DEVICE_ID_DEFAULT, `DEF_CLASS_HI, CLASS_LO_DEF[15:8], `DEF_SUBSYS, `DEF_SUBSYS};
    assign busy = (st_q != LD_IDLE) && (st_q != LD_DONE);

    // Loader sequence
    always_comb begin
        st_d = st_q;
        waddr_d = waddr_q;
        aword_d = aword_q;
        dword_d = dword_q;
        fields_d = fields_q;
        field_loaded_from_nvm_d = field_loaded_from_nvm_q;
        done_d = done_q;
        rd_start_d = 1'b0;
        perr_d = perr_q & ~perr_clr;
        case (st_q)
            LD_IDLE, LD_DONE: begin
                if (kick_q || reload) begin
                    st_d = LD_ADDR;
                    waddr_d = 6'h00;
                    fields_d = dflt;
                    field_loaded_from_nvm_d = 6'h00;
                    done_d = 1'b0;
                    rd_start_d = 1'b1;
                end
            end
            LD_ADDR: begin
                if (rd_valid) begin
                    aword_d = rd_word;
                    waddr_d = waddr_q + 6'h01;
                    rd_start_d = 1'b1;
                    st_d = LD_DATA;
                end
            end
            LD_DATA: begin
                if (rd_valid) begin
                    dword_d = rd_word;
                    st_d = LD_APPLY;
                end
            end
            LD_APPLY: begin
                if (!info.parity_ok) begin
                    perr_d = 1'b1;
                end else begin
                    case (info.target)
                        `TGT_VENDOR: fields_d.vendor = dword_q;
                        `TGT_DEVICE: fields_d.device = dword_q;
                        `TGT_CLASS_LO: fields_d.class_code[7:0] = dword_q[15:8];
                        `TGT_CLASS_HI: fields_d.class_code[23:8] = dword_q;
                        `TGT_SS_VENDOR: fields_d.ss_vendor = dword_q;
                        `TGT_SS_ID: fields_d.ss_id = dword_q;
                        default: ;
                    endcase
                    if (info.target < `NUM_TARGETS) begin
                        field_loaded_from_nvm_d[info.target[2:0]] = 1'b1;
                    end
                end
                if (info.last || waddr_q == `NVM_LAST_ADDR) begin
                    st_d = LD_DONE;
                    done_d = 1'b1;
                end else begin
                    waddr_d = waddr_q + 6'h01;
                    rd_start_d = 1'b1;
                    st_d = LD_ADDR;
                end
            end
            default: st_d = LD_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_q <= LD_IDLE;
            waddr_q <= 6'h00;
            aword_q <= 16'h0000;
            dword_q <= 16'h0000;
            fields_q <= '0;
            field_loaded_from_nvm_q <= 6'h00;
            perr_q <= 1'b0;
            done_q <= 1'b0;
            rd_start_q <= 1'b0;
            kick_q <= 1'b1;
        end else begin
            st_q <= st_d;
            waddr_q <= waddr_d;
            aword_q <= aword_d;
            dword_q <= dword_d;
            fields_q <= fields_d;
            field_loaded_from_nvm_q <= field_loaded_from_nvm_d;
            perr_q <= perr_d;
            done_q <= done_d;
            rd_start_q <= rd_start_d;
            kick_q <= 1'b0;
        end
    end

    // APB slave
    assign setup = psel && !penable;
    assign access = psel && penable && pready_q;
    assign mapped = (paddr == `OFS_IDS) || (paddr == `OFS_CLASS) || (paddr == `OFS_SUBSYS) ||
                    (paddr == `OFS_CTRL) || (paddr == `OFS_LOADER_STATUS_REG);
    assign reload = access && pwrite && (paddr == `OFS_CTRL) && pwdata[`CTRL_RELOAD_BIT];
    assign perr_clr = access && pwrite && (paddr == `OFS_LOADER_STATUS_REG) && pwdata[`ST_PARITY_BIT];
    assign visible = done_q ? fields_q : dflt;

    always_comb begin
        rd_mux = 32'h00000000;
        case (paddr)
            `OFS_IDS: rd_mux = {visible.device, visible.vendor};
            `OFS_CLASS: rd_mux = {8'h00, visible.class_code};
            `OFS_SUBSYS: rd_mux = {visible.ss_id, visible.ss_vendor};
            `OFS_LOADER_STATUS_REG: begin
                rd_mux[`ST_DONE_BIT] = done_q;
                rd_mux[`ST_BUSY_BIT] = busy;
                rd_mux[`ST_PARITY_BIT] = perr_q;
                rd_mux[`ST_LOADED_LSB +: 6] = field_loaded_from_nvm_q;
            end
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_comb begin
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        prdata_d = prdata_q;
        if (setup) begin
            pready_d = 1'b1;
            pslverr_d = ~mapped;
            prdata_d = pwrite ? 32'h00000000 : rd_mux;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // Checks
    logic [7:0] dword_hi;
    assign dword_hi = dword_q[15:8];
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n_q);

    sequence s_bad_pair;
        st_q == LD_APPLY && !info.parity_ok;
    endsequence
    sequence s_good_pair(logic [7:0] code);
        st_q == LD_APPLY && info.parity_ok && info.target == code;
    endsequence
    sequence s_kick;
        (st_q == LD_IDLE || st_q == LD_DONE) && (kick_q || reload);
    endsequence

    property p_parity_flag;
        s_bad_pair |=> perr_q ##1 (perr_q || $past(perr_clr));
    endproperty
    a_parity_flag: assert property (p_parity_flag) else $error("parity error not flagged");
    property p_bad_pair_dropped;
        s_bad_pair |=> $stable(fields_q);
    endproperty
    a_bad_pair_dropped: assert property (p_bad_pair_dropped) else $error("bad pair was applied");
    property p_final_stop;
        st_q == LD_APPLY && info.last |=> st_q == LD_DONE && done_q && !rd_start_q;
    endproperty
    a_final_stop: assert property (p_final_stop) else $error("loading went on after final pair");
    property p_continue;
        st_q == LD_APPLY && !info.last && waddr_q != `NVM_LAST_ADDR |=> st_q == LD_ADDR && rd_start_q;
    endproperty
    a_continue: assert property (p_continue) else $error("loading stopped early");
    property p_vendor_load;
        s_good_pair(`TGT_VENDOR) |=> fields_q.vendor == $past(dword_q);
    endproperty
    a_vendor_load: assert property (p_vendor_load) else $error("vendor id not loaded");
    property p_class_lo_load;
        s_good_pair(`TGT_CLASS_LO) |=> fields_q.class_code[7:0] == $past(dword_hi);
    endproperty
    a_class_lo_load: assert property (p_class_lo_load) else $error("class low byte wrong");
    property p_restart_defaults;
        s_kick |=> fields_q == dflt && waddr_q == 6'h00 && rd_start_q ##1 !rd_start_q;
    endproperty
    a_restart_defaults: assert property (p_restart_defaults) else $error("load did not start from defaults");
    property p_pair_order;
        st_q == LD_ADDR && rd_valid |=> st_q == LD_DATA && waddr_q == $past(waddr_q) + 6'h01;
    endproperty
    a_pair_order: assert property (p_pair_order) else $error("data word not read after address");
    property p_defaults_hidden;
        !done_q && setup && !pwrite && paddr == `OFS_IDS |=> prdata_q == {DEVICE_ID_DEFAULT, VENDOR_ID_DEFAULT};
    endproperty
    a_defaults_hidden: assert property (p_defaults_hidden) else $error("loaded ids visible before done");
endmodule : eeprom_config_loader

// [verilog/nvm_word_reader.sv]
// Serial read of one 16-bit word from the configuration memory
`timescale 1ns/100ps
`include "eeprom_config_loader_cfg.svh"
module nvm_word_reader import eeprom_config_loader_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic start,
    input wire logic [5:0] word_addr,
    input wire logic miso_s,
    output logic word_valid,
    output logic [15:0] word,
    output logic cs,
    output logic sk,
    output logic mosi
);
    read_state_t st_q, st_d;
    logic [4:0] bit_q, bit_d;
    logic [15:0] sh_q, sh_d;
    logic [8:0] cmd;
    logic sk_q, sk_d, cs_q, cs_d, do_q, do_d, vld_q, vld_d;

    assign cmd = {`NVM_CMD_READ, word_addr};

    always_comb begin
        st_d = st_q;
        bit_d = bit_q;
        sh_d = sh_q;
        sk_d = sk_q;
        cs_d = cs_q;
        do_d = do_q;
        vld_d = 1'b0;
        case (st_q)
            RD_IDLE: begin
                if (start) begin
                    st_d = RD_SHIFT;
                    cs_d = 1'b1;
                    sk_d = 1'b0;
                    bit_d = 5'h00;
                    do_d = cmd[8];
                end
            end
            RD_SHIFT: begin
                if (tick && !sk_q) begin
                    sk_d = 1'b1;
                end else if (tick) begin
                    sk_d = 1'b0;
                    if (bit_q >= `NVM_DATA_FIRST) begin
                        sh_d = {sh_q[14:0], miso_s};
                    end
                    if (bit_q == `NVM_SHIFT_BITS - 5'h01) begin
                        st_d = RD_END;
                        do_d = 1'b0;
                    end else begin
                        bit_d = bit_q + 5'h01;
                        do_d = (bit_q < 5'h08) ? cmd[4'h7 - bit_q[3:0]] : 1'b0;
                    end
                end
            end
            RD_END: begin
                if (tick) begin
                    cs_d = 1'b0;
                    vld_d = 1'b1;
                    st_d = RD_IDLE;
                end
            end
            default: st_d = RD_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= RD_IDLE;
            bit_q <= 5'h00;
            sh_q <= 16'h0000;
            sk_q <= 1'b0;
            cs_q <= 1'b0;
            do_q <= 1'b0;
            vld_q <= 1'b0;
        end else begin
            st_q <= st_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            sk_q <= sk_d;
            cs_q <= cs_d;
            do_q <= do_d;
            vld_q <= vld_d;
        end
    end

    assign word_valid = vld_q;
    assign word = sh_q;
    assign cs = cs_q;
    assign sk = sk_q;
    assign mosi = do_q;

    property p_sk_only_in_frame;
        @(posedge clk_sys) disable iff (!rst_n) !cs_q |-> !sk_q;
    endproperty
    a_sk_only_in_frame: assert property (p_sk_only_in_frame) else $error("clock toggles outside frame");

    property p_word_at_frame_end;
        @(posedge clk_sys) disable iff (!rst_n) vld_q |-> !cs_q && $past(cs_q);
    endproperty
    a_word_at_frame_end: assert property (p_word_at_frame_end) else $error("word valid not at frame end");
endmodule : nvm_word_reader

// [verilog/pair_decoder.sv]
// Parity check and descriptor decode of one address/data pair
`timescale 1ns/100ps
`include "eeprom_config_loader_cfg.svh"
module pair_decoder import eeprom_config_loader_pkg::*; (
    input wire logic [15:0] addr_word,
    input wire logic [15:0] data_word,
    output pair_info_t info
);
    always_comb begin
        info.parity_ok = ^{addr_word, data_word};
        info.last = addr_word[`DESC_FINAL_BIT];
        info.target = addr_word[7:0];
    end
endmodule : pair_decoder
